// *** rtl/usr_top.sv ***
// Eight-stage universal shift register with AXI4-Lite status and capture
`timescale 1ns/1ps
module usr_top (
   input wire logic mclk,
   input wire logic rst_n,
   // Device pins
   input wire logic clk_in,
   input wire logic clear_n,
   input wire logic mode_sel_hi,
   input wire logic mode_sel_lo,
   input wire logic out_en_a_n,
   input wire logic out_en_b_n,
   input wire logic ser_in_right,
   input wire logic ser_in_left,
   input wire logic [7:0] par_in,
   output logic [7:0] par_out,
   output logic [7:0] par_oe,
   output logic ser_out_first,
   output logic ser_out_last,
   output logic capt_ready,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   // Stage bits and previous clk_in level for edge detection
   logic [7:0] stage_bits, next_stage_bits;
   logic clk_in_q, next_clk_in_q;
   // Software control: capture enable, overrun flag
   logic capt_en, next_capt_en;
   logic overrun, next_overrun;
   // Write channel holding state
   logic aw_held, next_aw_held;
   logic [3:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   // Read channel state
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   // Decoded events
   logic clk_rise;
   logic [1:0] mode;
   logic do_write;
   logic ar_take;
   logic float_io;
   logic load_edge;

   // Streams into and out of the capture buffer
   usr_stream_if capt_s ();
   usr_stream_if read_s ();

   // The buffer decouples load edges from software reads
   usr_buf usr_buf_inst (
      .mclk(mclk),
      .rst_n(rst_n),
      .fill(capt_s),
      .drain(read_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin-side decode

   // clk_in is sampled by mclk; a rising edge is a low-then-high pair
   // The shift clock must stay high and low for at least one mclk period
   // each, or the edge between them is missed
   assign clk_rise = clk_in & ~clk_in_q;
   assign mode = {mode_sel_hi, mode_sel_lo};
   assign load_edge = clk_rise && clear_n && (mode == usr_pkg::MODE_LOAD);

   // A write is performed once both halves are held and no answer stands
   assign do_write = aw_held && w_held && !bvalid;

   ////////////////////////////////////////////////////////////////////////
   // Stage register next state
   // Clear is checked first so it overrides mode and clock edge
   // Software has no clear of its own: apart from clear_n and rst_n only a clk_in
   // rise moves the stages, so a bus write never disturbs a shift that
   // the outside logic has under way
   always_comb begin
      next_clk_in_q = clk_in;
      next_stage_bits = stage_bits;
      if (!clear_n) begin
         next_stage_bits = usr_pkg::STAGE_RST;
      end else if (clk_rise) begin
         case (mode)
            usr_pkg::MODE_LOAD: begin
               next_stage_bits = par_in;
            end
            usr_pkg::MODE_SHR: begin
               next_stage_bits = {stage_bits[6:0], ser_in_right};
            end
            usr_pkg::MODE_SHL: begin
               next_stage_bits = {ser_in_left, stage_bits[7:1]};
            end
            usr_pkg::MODE_HOLD: begin
               next_stage_bits = stage_bits;
            end
            default: begin
               next_stage_bits = stage_bits;
            end
         endcase
      end
   end

   // Stage flip-flops; output enables play no part here
   // clk_in_q restarts low, the idle level of clk_in, so reset makes no edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stage_bits <= usr_pkg::STAGE_RST;
         clk_in_q <= 1'b0;
      end else begin
         stage_bits <= next_stage_bits;
         clk_in_q <= next_clk_in_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs

   // Buffers float for either enable high or for load mode
   assign float_io = out_en_a_n | out_en_b_n
                     | (mode == usr_pkg::MODE_LOAD);

   // One driver per par_io line; clear shows zero at once, like the pins
   // par_oe is one enable copied to every line; the pad ring joins
   // par_out, par_oe and par_in into the two-way par_io pins
   generate
      for (genvar i = 0; i < usr_pkg::STAGES; i++) begin : g_io
         assign par_out[i] = stage_bits[i] & clear_n;
         assign par_oe[i] = ~float_io;
      end
   endgenerate

   // Serial ends ignore the output enables so chained stages keep working
   assign ser_out_first = stage_bits[0] & clear_n;
   assign ser_out_last = stage_bits[7] & clear_n;

   ////////////////////////////////////////////////////////////////////////
   // Capture path into the buffer

   // A word that meets a full buffer is lost; the overrun flag records it,
   // and capt_ready lets the outside logic hold off further loads
   // Each load edge offers the loaded word while capture is enabled
   assign capt_s.valid = load_edge && capt_en;
   assign capt_s.data = par_in;
   // Tells the outside logic a load would find room in the buffer
   assign capt_ready = capt_s.ready;

   ////////////////////////////////////////////////////////////////////////
   // Control and sticky overrun flag
   // Capture enable follows bit 0 of every control write that strobes byte 0
   always_comb begin
      next_capt_en = capt_en;
      next_overrun = overrun;
      if (do_write && (aw_addr == usr_pkg::CTRL_OFS) && w_strb[0]) begin
         next_capt_en = w_data[usr_pkg::CTRL_CAPT_EN_BIT];
      end
      // Write-one clears; a new overrun in the same cycle wins
      if (do_write && (aw_addr == usr_pkg::STATUS_OFS) && w_strb[1]
          && w_data[usr_pkg::STAT_OVERRUN_BIT]) begin
         next_overrun = 1'b0;
      end
      if (capt_s.valid && !capt_s.ready) begin
         next_overrun = 1'b1;
      end
   end

   // Control registers
   // Capture starts disabled so reset never fills the buffer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         capt_en <= usr_pkg::CTRL_CAPT_EN_RST;
         overrun <= 1'b0;
      end else begin
         capt_en <= next_capt_en;
         overrun <= next_overrun;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register map, one aligned word each:
   //   offset 0 control: bit 0 capture enable, read back; other bits ignored
   //   offset 4 status: stages, buffer not empty, buffer full, overrun
   //   offset 8 capture: oldest buffered word and a valid flag; a read pops
   //   any other offset answers with a slave error and has no effect
   // AXI4-Lite write channels
   // Address and data are taken in either order and held until both are
   // present; the response then stands until bready
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      // Capture each half when offered
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      // Perform the write and raise the response
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         if (aw_addr == usr_pkg::CTRL_OFS || aw_addr == usr_pkg::STATUS_OFS) begin
            next_bresp = usr_pkg::RESP_OKAY;
         end else begin
            next_bresp = usr_pkg::RESP_SLVERR;
         end
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // Write channel registers
   // Strobes are kept with the data so a partial write touches only its bytes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= usr_pkg::RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channels
   // One read at a time; a read of the capture register pops the buffer,
   // so an empty buffer answers with the valid flag low
   assign s_axi_arready = !rvalid;
   assign ar_take = s_axi_arvalid && !rvalid;
   assign read_s.ready = ar_take && (s_axi_araddr == usr_pkg::CAPTURE_OFS);

   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (ar_take) begin
         next_rvalid = 1'b1;
         next_rresp = usr_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         case (s_axi_araddr)
            usr_pkg::CTRL_OFS: begin
               next_rdata[usr_pkg::CTRL_CAPT_EN_BIT] = capt_en;
            end
            usr_pkg::STATUS_OFS: begin
               next_rdata[7:0] = stage_bits;
               next_rdata[usr_pkg::STAT_NOT_EMPTY_BIT] = read_s.valid;
               next_rdata[usr_pkg::STAT_FULL_BIT] = !capt_s.ready;
               next_rdata[usr_pkg::STAT_OVERRUN_BIT] = overrun;
            end
            usr_pkg::CAPTURE_OFS: begin
               next_rdata[7:0] = read_s.valid ? read_s.data : 8'h00;
               next_rdata[usr_pkg::CAPT_VALID_BIT] = read_s.valid;
            end
            default: begin
               next_rresp = usr_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Read channel registers
   // The answer is registered, so rdata stands unchanged until rready
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= usr_pkg::RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

endmodule

// *** rtl/usr_pkg.sv ***
// Shared constants for the universal shift register block
package usr_pkg;
   // Register word width and stage count
   localparam int unsigned STAGES = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;
   // Depth of the captured-word buffer
   localparam int unsigned BUF_DEPTH = 2;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] CAPTURE_OFS = 4'h8;
   // Control field positions
   localparam int unsigned CTRL_CAPT_EN_BIT = 0;
   localparam int unsigned CTRL_SOFT_CLR_BIT = 1;
   // Status field positions
   localparam int unsigned STAT_NOT_EMPTY_BIT = 8;
   localparam int unsigned STAT_FULL_BIT = 9;
   localparam int unsigned STAT_OVERRUN_BIT = 10;
   // Capture register valid flag position
   localparam int unsigned CAPT_VALID_BIT = 31;
   // Reset values
   localparam logic CTRL_CAPT_EN_RST = 1'b0;
   localparam logic [7:0] STAGE_RST = 8'h00;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Operating modes, coded as {mode_sel_hi, mode_sel_lo}
   localparam logic [1:0] MODE_HOLD = 2'h0;
   localparam logic [1:0] MODE_SHR = 2'h1;
   localparam logic [1:0] MODE_SHL = 2'h2;
   localparam logic [1:0] MODE_LOAD = 2'h3;
endpackage

// *** rtl/usr_stream_if.sv ***
// Valid/ready word stream between the shift register core and its buffer
`timescale 1ns/1ps
interface usr_stream_if;
   logic valid; // Word offered
   logic ready; // Word accepted
   logic [7:0] data; // Word payload
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** rtl/usr_buf.sv ***
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
module usr_buf (
   input wire logic mclk,
   input wire logic rst_n,
   usr_stream_if.snk fill,
   usr_stream_if.src drain
);
   // Storage entries, pointers and fill level
   logic [7:0] mem [usr_pkg::BUF_DEPTH];
   logic [7:0] next_mem [usr_pkg::BUF_DEPTH];
   logic wr_ptr, next_wr_ptr;
   logic rd_ptr, next_rd_ptr;
   logic [1:0] level, next_level;
   logic push, pop;

   // Honest full and empty drive both handshakes
   assign fill.ready = (level != 2'(usr_pkg::BUF_DEPTH));
   assign drain.valid = (level != 2'h0);
   assign drain.data = mem[rd_ptr];
   assign push = fill.valid & fill.ready;
   assign pop = drain.valid & drain.ready;

   ////////////////////////////////////////////////////////////////////////
   // Next-state computation
   always_comb begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level = level;
      if (push) begin
         next_mem[wr_ptr] = fill.data;
         next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      // Simultaneous push and pop leaves the level unchanged
      if (push && !pop) begin
         next_level = level + 2'h1;
      end else if (pop && !push) begin
         next_level = level - 2'h1;
      end
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < usr_pkg::BUF_DEPTH; i++) begin
            mem[i] <= 8'h00;
         end
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         level <= 2'h0;
      end else begin
         mem <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
   end
endmodule

// *** verif/usr_checker.sv ***
// Concurrent checks on the shift register pins and bus handshakes
`timescale 1ns/1ps
module usr_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_in,
   input wire logic clear_n,
   input wire logic mode_sel_hi,
   input wire logic mode_sel_lo,
   input wire logic out_en_a_n,
   input wire logic out_en_b_n,
   input wire logic ser_in_right,
   input wire logic ser_in_left,
   input wire logic [7:0] par_in,
   input wire logic [7:0] par_out,
   input wire logic [7:0] par_oe,
   input wire logic ser_out_first,
   input wire logic ser_out_last,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   logic clk_q; // Shift clock seen at the previous edge
   logic rise; // Sampled low-to-high step of the shift clock
   logic [1:0] mode; // Mode as {hi, lo}
   logic [7:0] oe_exp; // Expected drive enables
   // Mirrors the block: the history bit restarts low after reset
   always_ff @(posedge mclk) begin
      clk_q <= rst_n ? clk_in : 1'b0;
   end
   assign rise = clk_in && !clk_q;
   assign mode = {mode_sel_hi, mode_sel_lo};
   assign oe_exp = {8{!(out_en_a_n || out_en_b_n || mode == usr_pkg::MODE_LOAD)}};
   // Cycles with clear_n low are left out: the outputs read zero then
   sequence calm;
      clear_n;
   endsequence
   ////////////////////////////////////////////////////////////////
   chk_oe_float: assert property (par_oe == oe_exp)
      else $error("drive enable wrong");
   chk_clear_zero: assert property (!clear_n |-> par_out == 8'h00 && !ser_out_first
      && !ser_out_last) else $error("clear not applied");
   chk_ser_ends: assert property (ser_out_first == par_out[0]
      && ser_out_last == par_out[7]) else $error("serial ends wrong");
   chk_hold_still: assert property (clear_n && (!rise || mode == usr_pkg::MODE_HOLD)
      ##1 calm |-> $stable(par_out)) else $error("stages moved");
   chk_shift_right: assert property (rise && clear_n && mode == usr_pkg::MODE_SHR
      ##1 calm |-> par_out == {$past(par_out[6:0]), $past(ser_in_right)})
      else $error("right shift wrong");
   chk_shift_left: assert property (rise && clear_n && mode == usr_pkg::MODE_SHL
      ##1 calm |-> par_out == {$past(ser_in_left), $past(par_out[7:1])})
      else $error("left shift wrong");
   chk_load_par: assert property (rise && clear_n && mode == usr_pkg::MODE_LOAD
      ##1 calm |-> par_out == $past(par_in)) else $error("load wrong");
   chk_write_still: assert property ($rose(s_axi_bvalid) && clear_n && $past(clear_n)
      && !$past(rise) |-> $stable(par_out)) else $error("stages moved on a bus write");
   chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   cov_shr: cover property (rise && mode == usr_pkg::MODE_SHR);
   cov_shl: cover property (rise && mode == usr_pkg::MODE_SHL);
   cov_load: cover property (rise && mode == usr_pkg::MODE_LOAD);
   cov_clear: cover property (!clear_n);
endmodule
bind usr_top usr_checker usr_checker_inst (.mclk(mclk), .rst_n(rst_n), .clk_in(clk_in),
   .clear_n(clear_n), .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo),
   .out_en_a_n(out_en_a_n), .out_en_b_n(out_en_b_n), .ser_in_right(ser_in_right),
   .ser_in_left(ser_in_left), .par_in(par_in), .par_out(par_out), .par_oe(par_oe),
   .ser_out_first(ser_out_first), .ser_out_last(ser_out_last),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** verif/usr_far_side.sv ***
// Far-side bus controller model sharing the parallel lines
`timescale 1ns/1ps
module usr_far_side (
   input wire logic mclk,
   input wire logic [7:0] par_oe,
   input wire logic [7:0] par_out,
   input wire logic drv_en,
   input wire logic [7:0] drv_data,
   output logic [7:0] par_in
);
   logic [7:0] last; // Level of the lines at the previous edge
   // Device first; this model only while the device floats; else no stale value
   always_comb begin
      if (par_oe[0])
         par_in = par_out;
      else if (drv_en)
         par_in = drv_data;
      else
         par_in = ~last;
   end
   // Remember the line levels so a floated bus shows their inverse
   always_ff @(posedge mclk) begin
      last <= par_in;
   end
endmodule

// *** verif/tb_usr_top.sv ***
// Self-checking bench for the universal shift register block
`timescale 1ns/1ps
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_usr_top;
   logic mclk, rst_n, clk_in, clear_n, mode_sel_hi, mode_sel_lo, drv_en;
   logic out_en_a_n, out_en_b_n, ser_in_right, ser_in_left, capt_ready;
   logic [7:0] par_in, par_out, par_oe, drv_data, exp;
   logic ser_out_first, ser_out_last, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   int failures, num_checks;
   usr_top usr_top_inst (.mclk(mclk), .rst_n(rst_n), .clk_in(clk_in), .clear_n(clear_n),
      .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo), .out_en_a_n(out_en_a_n),
      .out_en_b_n(out_en_b_n), .ser_in_right(ser_in_right), .ser_in_left(ser_in_left),
      .par_in(par_in), .par_out(par_out), .par_oe(par_oe), .ser_out_first(ser_out_first),
      .ser_out_last(ser_out_last), .capt_ready(capt_ready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   usr_far_side usr_far_side_inst (.mclk(mclk), .par_oe(par_oe), .par_out(par_out),
      .drv_en(drv_en), .drv_data(drv_data), .par_in(par_in));
   ////////////////////////////////////////////////////////////////
   // 25 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Bus write: address and data offered together, each dropped once taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Bus read: answer taken at the edge where rvalid is seen
   task automatic axr(input logic [3:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // One shift-clock pulse; mode and data stay put past the edge
   task automatic pulse(input logic [1:0] m);
      @(posedge mclk);
      {mode_sel_hi, mode_sel_lo} <= m;
      @(posedge mclk);
      clk_in <= 1'b1;
      @(posedge mclk);
      clk_in <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic end_sim;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Whole run is near 100 cycles; ten thousand means a hang
   initial begin
      repeat (10000) @(posedge mclk);
      failures++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, clk_in, mode_sel_hi, mode_sel_lo, drv_en, ser_in_right, ser_in_left} = 7'h00;
      {clear_n, out_en_a_n, out_en_b_n, s_axi_awvalid, s_axi_wvalid} = 5'h10;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00f;
      {s_axi_wdata, drv_data} = 40'h0;
      failures = 0;
      num_checks = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      axr(usr_pkg::STATUS_OFS);
      `CK(rd, 32'h0000_0000)
      axr(4'hc);
      `CK(rsp, usr_pkg::RESP_SLVERR)
      axw(4'hc, 32'h0000_0001);
      `CK(rsp, usr_pkg::RESP_SLVERR)
      $display("test reset done");
      drv_data <= 8'ha5;
      drv_en <= 1'b1;
      pulse(usr_pkg::MODE_LOAD);
      `CK(par_oe, 8'h00)
      exp = 8'ha5;
      `CK(par_out, exp)
      drv_en <= 1'b0;
      pulse(usr_pkg::MODE_HOLD);
      `CK(par_oe, 8'hff)
      `CK(par_in, exp)
      `CK(par_out, exp)
      $display("test load done");
      out_en_a_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         ser_in_right <= i[0];
         pulse(usr_pkg::MODE_SHR);
         exp = {exp[6:0], i[0]};
         `CK(par_out, exp)
      end
      `CK(par_oe, 8'h00)
      out_en_a_n <= 1'b0;
      out_en_b_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         ser_in_left <= ~i[0];
         pulse(usr_pkg::MODE_SHL);
         exp = {~i[0], exp[7:1]};
         `CK(par_out, exp)
      end
      `CK(par_oe, 8'h00)
      out_en_b_n <= 1'b0;
      ser_in_right <= ser_out_last;
      pulse(usr_pkg::MODE_SHR);
      exp = {exp[6:0], exp[7]};
      `CK({ser_out_last, ser_out_first}, {exp[7], exp[0]})
      $display("test shift done");
      clear_n <= 1'b0;
      @(posedge mclk);
      `CK({ser_out_first, ser_out_last, par_out}, 10'h000)
      clear_n <= 1'b1;
      axr(usr_pkg::STATUS_OFS);
      `CK(rd[7:0], 8'h00)
      $display("test clear done");
      axw(usr_pkg::CTRL_OFS, 32'h0000_0001);
      drv_en <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         drv_data <= 8'h30 + i[7:0];
         pulse(usr_pkg::MODE_LOAD);
      end
      drv_en <= 1'b0;
      `CK(capt_ready, 1'b0)
      axr(usr_pkg::STATUS_OFS);
      `CK(rd[10:0], 11'h732)
      for (int i = 0; i < 2; i++) begin
         axr(usr_pkg::CAPTURE_OFS);
         `CK(rd, 32'h8000_0030 + 32'(i))
      end
      axr(usr_pkg::CAPTURE_OFS);
      `CK(rd[31], 1'b0)
      axw(usr_pkg::STATUS_OFS, 32'h0000_0400);
      axw(usr_pkg::CTRL_OFS, 32'h0000_0002);
      axr(usr_pkg::STATUS_OFS);
      `CK(rd[10:0], 11'h032)
      axr(usr_pkg::CTRL_OFS);
      `CK(rd, 32'h0000_0000)
      $display("test capture done");
      end_sim();
   end
endmodule
